// >>> src/fclsc_bus.sv
// single flash bus cycle engine: chip enable, write or output enable strobe
module fclsc_bus (
   input  wire logic                 i_mclk,
   input  wire logic                 i_resetn,
   input  wire logic                 i_ce,
   input  wire logic                 i_req_valid,
   input  wire fclsc_pkg::fclsc_req_t i_req,
   input  wire logic [7:0]           i_dq,
   output logic                      o_done,
   output logic [7:0]                o_rdata,
   output logic                      o_flash_ce_n,
   output logic                      o_flash_we_n,
   output logic                      o_flash_oe_n,
   output logic [7:0]                o_dq,
   output logic                      o_dq_oe
);

   typedef enum logic [1:0] {
      B_IDLE  = 2'b00,
      B_SETUP = 2'b01,
      B_PULSE = 2'b10,
      B_HOLD  = 2'b11
   } fclsc_bst_t;

   fclsc_bst_t state_q;
   logic [3:0] cnt_q;
   logic       wr_q;

   // cycle sequencing: setup, strobe low, hold, then done pulse
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q      <= B_IDLE;
         cnt_q        <= 4'h0;
         wr_q         <= 1'b0;
         o_done       <= 1'b0;
         o_flash_ce_n <= 1'b1;
         o_flash_we_n <= 1'b1;
         o_flash_oe_n <= 1'b1;
         o_dq         <= 8'h00;
         o_dq_oe      <= 1'b0;
      end else if (i_ce) begin
         o_done <= 1'b0;
         unique case (state_q)
            B_IDLE: begin
               if (i_req_valid) begin
                  wr_q         <= i_req.wr;
                  o_dq         <= i_req.data;
                  o_dq_oe      <= i_req.wr;
                  o_flash_ce_n <= 1'b0;
                  cnt_q        <= fclsc_pkg::SETUP_CYC;
                  state_q      <= B_SETUP;
               end
            end
            B_SETUP: begin
               if (cnt_q == 4'h1) begin
                  o_flash_we_n <= ~wr_q;
                  o_flash_oe_n <= wr_q;
                  cnt_q        <= fclsc_pkg::PULSE_CYC;
                  state_q      <= B_PULSE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            B_PULSE: begin
               if (cnt_q == 4'h1) begin
                  o_flash_we_n <= 1'b1; // data latched on this rise
                  o_flash_oe_n <= 1'b1;
                  cnt_q        <= fclsc_pkg::HOLD_CYC;
                  state_q      <= B_HOLD;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            B_HOLD: begin
               if (cnt_q == 4'h1) begin
                  o_flash_ce_n <= 1'b1;
                  o_dq_oe      <= 1'b0;
                  o_done       <= 1'b1;
                  state_q      <= B_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   // read data sampled in the last strobe cycle, before output enable rises
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 8'h00;
      end else if (i_ce && state_q == B_PULSE && cnt_q == 4'h1 && !wr_q) begin
         o_rdata <= i_dq;
      end
   end

endmodule // fclsc_bus

// >>> src/fclsc_host.sv
// host controller: clears lock bits and configures the flash status pin
//
// Design decisions made here: register access over APB and the placing of the registers.
module fclsc_host (
   input  wire logic        i_mclk,
   input  wire logic        i_resetn,
   input  wire logic        i_ce,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic [7:0]  i_dq,
   input  wire logic        i_status_output_pin,
   output logic             o_flash_ce_n,
   output logic             o_flash_we_n,
   output logic             o_flash_oe_n,
   output logic [7:0]       o_dq,
   output logic             o_dq_oe,
   output logic             o_reset_powerdown_pin_n,
   output logic             o_override_high_voltage_en
);

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_W1   = 3'b001,
      S_W2   = 3'b010,
      S_POLL = 3'b011,
      S_RD   = 3'b100,
      S_CLR  = 3'b101,
      S_FIN  = 3'b110
   } fclsc_st_t;

   fclsc_st_t             state_q;
   fclsc_pkg::fclsc_op_t  op_q;
   fclsc_pkg::fclsc_req_t req_q;
   logic                  req_valid_q;
   logic                  bus_done;
   logic [7:0]            bus_rdata;
   logic [31:0]           cfg_q;
   logic [7:0]            sr_q;
   logic                  done_q;
   logic                  clr_err_q;
   logic                  locks_unk_q;
   logic                  seq_err_q;
   logic [1:0]            mode_q;
   logic                  pin_q;
   logic [15:0]           pulses_q;
   logic                  wr_acc;
   logic                  rd_setup;
   logic                  busy;
   logic [31:0]           stat_word;

   // bus cycle request helper: write a byte or read one
   function automatic fclsc_pkg::fclsc_req_t mk_req(input logic wr,
                                                    input logic [7:0] d);
      fclsc_pkg::fclsc_req_t r;
      r.wr   = wr;
      r.data = d;
      return r;
   endfunction

   assign wr_acc   = i_psel & i_penable & o_pready & i_pwrite;
   assign rd_setup = i_psel & ~i_penable;
   assign busy     = (state_q != S_IDLE);

   // status word seen by software
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[7:0] = sr_q;
      stat_word[fclsc_pkg::ST_BUSY] = busy;
      stat_word[fclsc_pkg::ST_DONE] = done_q;
      stat_word[fclsc_pkg::ST_CLR_ERR] = clr_err_q;
      stat_word[fclsc_pkg::ST_LOCKS_UNK] = locks_unk_q;
      stat_word[fclsc_pkg::ST_SEQ_ERR] = seq_err_q;
      stat_word[fclsc_pkg::ST_MODE_LSB +: 2] = mode_q;
      stat_word[fclsc_pkg::ST_PIN] = pin_q;
   end

   // apb slave: one access cycle, unmapped offsets answer with an error
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else if (i_ce) begin
         o_pready  <= rd_setup;
         o_pslverr <= 1'b0;
         if (rd_setup) begin
            o_prdata <= 32'h0000_0000;
            unique case (i_paddr)
               fclsc_pkg::OFS_CTRL:   o_prdata <= 32'h0000_0000;
               fclsc_pkg::OFS_CFG:    o_prdata <= cfg_q;
               fclsc_pkg::OFS_STAT:   o_prdata <= stat_word;
               fclsc_pkg::OFS_PULSES: o_prdata <= {16'h0000, pulses_q};
               default:               o_pslverr <= 1'b1;
            endcase
         end
      end
   end

   // configuration register: code, reset pin level, override request
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_q <= fclsc_pkg::CFG_RESET;
      end else if (i_ce && wr_acc && i_paddr == fclsc_pkg::OFS_CFG) begin
         cfg_q <= i_pwdata & 32'h0000_0033;
      end
   end

   // pins driven toward the flash reset input
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reset_powerdown_pin_n    <= 1'b1;
         o_override_high_voltage_en <= 1'b0;
      end else if (i_ce) begin
         o_reset_powerdown_pin_n    <= ~cfg_q[fclsc_pkg::CFG_RP_LOW];
         // raising the pin lets a locked master bit be overridden
         o_override_high_voltage_en <= cfg_q[fclsc_pkg::CFG_OVERRIDE];
      end
   end

   // command sequencer
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q     <= S_IDLE;
         op_q        <= fclsc_pkg::OP_NONE;
         req_q       <= '0;
         req_valid_q <= 1'b0;
      end else if (i_ce) begin
         req_valid_q <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               if (wr_acc && i_paddr == fclsc_pkg::OFS_CTRL) begin
                  if (i_pwdata[fclsc_pkg::CTRL_GO_CLEAR]) begin
                     op_q  <= fclsc_pkg::OP_CLEAR;
                     req_q <= mk_req(1'b1, fclsc_pkg::CMD_CLR_SETUP);
                  end else if (i_pwdata[fclsc_pkg::CTRL_GO_CFG]) begin
                     op_q  <= fclsc_pkg::OP_CFG;
                     req_q <= mk_req(1'b1, fclsc_pkg::CMD_CFG);
                  end else if (i_pwdata[fclsc_pkg::CTRL_GO_CLRSTS]) begin
                     op_q  <= fclsc_pkg::OP_CLRSTS;
                     req_q <= mk_req(1'b1, fclsc_pkg::CMD_CLR_STATUS);
                  end else begin
                     op_q  <= fclsc_pkg::OP_RDSTS;
                     req_q <= mk_req(1'b1, fclsc_pkg::CMD_RD_STATUS);
                  end
                  if (i_pwdata[3:0] != 4'h0) begin
                     req_valid_q <= 1'b1;
                     state_q     <= S_W1;
                  end
               end
            end
            S_W1: begin
               if (bus_done) begin
                  req_valid_q <= 1'b1;
                  unique case (op_q)
                     fclsc_pkg::OP_CLEAR: begin
                        req_q   <= mk_req(1'b1,
                                          fclsc_pkg::CMD_CLR_CONFIRM);
                        state_q <= S_W2;
                     end
                     fclsc_pkg::OP_CFG: begin
                        // upper six data bits forced to zero
                        req_q   <= mk_req(1'b1, cfg_q[7:0]
                                          & fclsc_pkg::CFG_CODE_MASK);
                        state_q <= S_W2;
                     end
                     fclsc_pkg::OP_RDSTS: begin
                        req_q   <= mk_req(1'b0, 8'h00);
                        state_q <= S_RD;
                     end
                     default: begin
                        req_valid_q <= 1'b0;
                        state_q     <= S_FIN;
                     end
                  endcase
               end
            end
            S_W2: begin
               if (bus_done) begin
                  if (op_q == fclsc_pkg::OP_CLEAR) begin
                     // device answers reads with status from here on
                     req_q       <= mk_req(1'b0, 8'h00);
                     req_valid_q <= 1'b1;
                     state_q     <= S_POLL;
                  end else begin
                     state_q <= S_FIN;
                  end
               end
            end
            S_POLL: begin
               if (bus_done) begin
                  if (!bus_rdata[fclsc_pkg::SR_READY_BIT]) begin
                     req_valid_q <= 1'b1; // still busy, read again
                  end else if (bus_rdata[fclsc_pkg::SR_ERASE_ERR]) begin
                     req_q       <= mk_req(1'b1,
                                           fclsc_pkg::CMD_CLR_STATUS);
                     req_valid_q <= 1'b1;
                     state_q     <= S_CLR;
                  end else begin
                     state_q <= S_FIN;
                  end
               end
            end
            S_RD: begin
               if (bus_done) begin
                  state_q <= S_FIN;
               end
            end
            S_CLR: begin
               if (bus_done) begin
                  state_q <= S_FIN;
               end
            end
            S_FIN: begin
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // last status byte read and the error summary drawn from it
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         sr_q      <= 8'h00;
         clr_err_q <= 1'b0;
         seq_err_q <= 1'b0;
      end else if (i_ce && bus_done
                   && (state_q == S_POLL || state_q == S_RD)) begin
         sr_q <= bus_rdata;
         if (state_q == S_POLL && bus_rdata[fclsc_pkg::SR_READY_BIT]) begin
            clr_err_q <= bus_rdata[fclsc_pkg::SR_ERASE_ERR];
            // both error bits mark a refused sequence or code
            seq_err_q <= bus_rdata[fclsc_pkg::SR_ERASE_ERR]
                         & bus_rdata[fclsc_pkg::SR_PROG_ERR];
         end
      end
   end

   // done flag: set by completion, cleared by software, set wins
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         done_q <= 1'b0;
      end else if (i_ce) begin
         if (state_q == S_FIN) begin
            done_q <= 1'b1;
         end else if (wr_acc && i_paddr == fclsc_pkg::OFS_CTRL
                      && i_pwdata[fclsc_pkg::CTRL_ACK_DONE]) begin
            done_q <= 1'b0;
         end
      end
   end

   // reset during a clear leaves locks unknown until a clean clear
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         locks_unk_q <= 1'b0;
      end else if (i_ce) begin
         if (op_q == fclsc_pkg::OP_CLEAR && busy
             && !o_reset_powerdown_pin_n) begin
            locks_unk_q <= 1'b1;
         end else if (state_q == S_POLL && bus_done
                      && bus_rdata[fclsc_pkg::SR_READY_BIT]
                      && !bus_rdata[fclsc_pkg::SR_ERASE_ERR]) begin
            locks_unk_q <= 1'b0;
         end
      end
   end

   // mirror of the pin mode held in the flash
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_q <= 2'b00;
      end else if (i_ce) begin
         if (!o_reset_powerdown_pin_n) begin
            mode_q <= 2'b00;
         end else if (op_q == fclsc_pkg::OP_CFG && state_q == S_W2
                      && bus_done) begin
            mode_q <= cfg_q[fclsc_pkg::CFG_CODE_LSB +: 2];
         end
      end
   end

   // status pin level and completion pulse count in pulse modes
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_q    <= 1'b1;
         pulses_q <= 16'h0000;
      end else if (i_ce) begin
         pin_q <= i_status_output_pin;
         if (mode_q != 2'b00 && pin_q && !i_status_output_pin) begin
            pulses_q <= pulses_q + 16'h0001;
         end
      end
   end

   fclsc_bus u_bus (
      .i_mclk       (i_mclk),
      .i_resetn     (i_resetn),
      .i_ce         (i_ce),
      .i_req_valid  (req_valid_q),
      .i_req        (req_q),
      .i_dq         (i_dq),
      .o_done       (bus_done),
      .o_rdata      (bus_rdata),
      .o_flash_ce_n (o_flash_ce_n),
      .o_flash_we_n (o_flash_we_n),
      .o_flash_oe_n (o_flash_oe_n),
      .o_dq         (o_dq),
      .o_dq_oe      (o_dq_oe)
   );

endmodule // fclsc_host

// >>> src/fclsc_pkg.sv
// shared constants and types of the flash lock-clear and status-pin host
package fclsc_pkg;

   // flash command bytes and the configuration code mask
   localparam logic [7:0] CMD_CFG         = 8'hb8;
   localparam logic [7:0] CMD_CLR_SETUP   = 8'h60;
   localparam logic [7:0] CMD_CLR_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
   localparam logic [7:0] CMD_RD_STATUS   = 8'h70;
   localparam logic [7:0] CFG_CODE_MASK   = 8'h03;

   // flash status byte bit positions
   localparam int SR_READY_BIT   = 7;
   localparam int SR_ERASE_ERR   = 5;
   localparam int SR_PROG_ERR    = 4;
   localparam int SR_LOW_SUPPLY  = 3;
   localparam int SR_PROTECT     = 1;

   // apb register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CFG    = 8'h04;
   localparam logic [7:0] OFS_STAT   = 8'h08;
   localparam logic [7:0] OFS_PULSES = 8'h0c;

   // control register bits (write one to start, or to acknowledge done)
   localparam int CTRL_GO_CLEAR  = 0;
   localparam int CTRL_GO_CFG    = 1;
   localparam int CTRL_GO_CLRSTS = 2;
   localparam int CTRL_GO_RDSTS  = 3;
   localparam int CTRL_ACK_DONE  = 4;

   // configuration register fields
   localparam int CFG_CODE_LSB  = 0;
   localparam int CFG_RP_LOW    = 4;
   localparam int CFG_OVERRIDE  = 5;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // status register fields
   localparam int ST_BUSY       = 8;
   localparam int ST_DONE       = 9;
   localparam int ST_CLR_ERR    = 10;
   localparam int ST_LOCKS_UNK  = 11;
   localparam int ST_SEQ_ERR    = 12;
   localparam int ST_MODE_LSB   = 13;
   localparam int ST_PIN        = 15;

   // flash bus cycle timing
   localparam int CLK_NS     = 40;
   localparam int SETUP_NS   = 40;
   localparam int PULSE_NS   = 80;
   localparam int HOLD_NS    = 40;
   localparam logic [3:0] SETUP_CYC =
      4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] PULSE_CYC =
      4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC =
      4'((HOLD_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_CLEAR  = 3'b001,
      OP_CFG    = 3'b010,
      OP_CLRSTS = 3'b011,
      OP_RDSTS  = 3'b100
   } fclsc_op_t;

   // one flash bus cycle request
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } fclsc_req_t;

endpackage

// >>> verification/fclsc_flash_model.sv
// behavioural flash device: lock bits, status byte, status pin
module fclsc_flash_model #(
   parameter int BUSY_CYC  = 50,
   parameter int PULSE_LEN = 7
) (
   input  wire logic       i_clk,
   input  wire logic       i_ce_n,
   input  wire logic       i_we_n,
   input  wire logic       i_oe_n,
   input  wire logic [7:0] i_dq,
   input  wire logic       i_rp_n,
   input  wire logic       i_hv,
   input  wire logic       i_master,
   input  wire logic       i_low_supply,
   output logic [7:0]      o_dq,
   output logic            o_sts
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sr_q = 8'h00;
   logic [7:0] prev_q = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic [3:0] locks_q = 4'hf; // survives reset
   logic [1:0] mode_q = 2'b00;
   logic       we_q = 1'b1;
   logic       rds_q = 1'b0;
   logic       unk_q = 1'b0;
   int         busy_q = 0;
   int         pulse_q = 0;
   logic [7:0] stat;
   // ready flag, pin level or pulse, released lines flip
   assign stat = {busy_q == 0, sr_q[6:0]};
   assign o_sts = (mode_q == 2'b00) ? busy_q == 0 : pulse_q == 0;
   assign o_dq = (!i_ce_n && !i_oe_n) ? (rds_q ? stat : 8'h00) : ~last_q;
   // command decode and operation timing
   always @(posedge i_clk) begin
      we_q <= i_we_n;
      if (!i_ce_n && !i_oe_n) last_q <= o_dq;
      if (pulse_q > 0) pulse_q <= pulse_q - 1;
      if (!i_rp_n) begin
         mode_q <= 2'b00;
         prev_q <= 8'h00;
         if (busy_q > 0) unk_q <= 1'b1;
         busy_q <= 0;
      end else begin
         if (busy_q > 0) busy_q <= busy_q - 1;
         if (busy_q == 1) begin
            locks_q <= 4'h0;
            unk_q <= 1'b0;
            if (mode_q[0]) pulse_q <= PULSE_LEN;
         end
         if (i_we_n && !we_q && !i_ce_n) begin
            prev_q <= 8'h00;
            rds_q <= 1'b1;
            if (prev_q == fclsc_pkg::CMD_CLR_SETUP) begin
               if (i_dq != fclsc_pkg::CMD_CLR_CONFIRM || busy_q > 0)
                  sr_q[5:4] <= 2'b11;
               else if (i_low_supply) sr_q <= sr_q | 8'h28;
               else if (i_master && !i_hv) sr_q <= sr_q | 8'h22;
               else busy_q <= BUSY_CYC;
            end else if (prev_q == fclsc_pkg::CMD_CFG) begin
               if (i_dq[7:2] != 6'h00) sr_q[5:4] <= 2'b11;
               else mode_q <= i_dq[1:0];
            end else begin
               prev_q <= i_dq;
               if (i_dq == fclsc_pkg::CMD_CLR_STATUS) sr_q[5:1] <= 5'h00;
            end
         end
      end
   end
endmodule // fclsc_flash_model

// >>> verification/fclsc_host_sva.sv
// port assertions of the flash lock-clear host
module fclsc_host_sva (
   input wire logic       i_mclk,
   input wire logic       i_resetn,
   input wire logic       i_ce,
   input wire logic       i_psel,
   input wire logic       i_penable,
   input wire logic [7:0] i_paddr,
   input wire logic       o_pready,
   input wire logic       o_pslverr,
   input wire logic       o_flash_ce_n,
   input wire logic       o_flash_we_n,
   input wire logic       o_flash_oe_n,
   input wire logic [7:0] o_dq,
   input wire logic       o_dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   logic [7:0] last_q;
   // last byte strobed into the flash
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) last_q <= 8'h00;
      else if ($fell(o_flash_we_n)) last_q <= o_dq;
   end
   property p_rdy_setup;
      i_ce && i_psel && !i_penable |=> o_pready;
   endproperty
   a_rdy_setup: assert property (p_rdy_setup)
      else $error("no ready after setup");
   property p_rdy_one;
      o_pready && i_ce |=> !o_pready;
   endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
   property p_err_bad;
      o_pready && i_paddr > 8'h0c |-> o_pslverr;
   endproperty
   a_err_bad: assert property (p_err_bad) else $error("no slave error");
   property p_err_good;
      o_pready && i_paddr[1:0] == 2'b00 && i_paddr <= 8'h0c |-> !o_pslverr;
   endproperty
   a_err_good: assert property (p_err_good) else $error("false error");
   property p_strobe_sel;
      !o_flash_we_n || !o_flash_oe_n |-> !o_flash_ce_n;
   endproperty
   a_strobe_sel: assert property (p_strobe_sel) else $error("strobe no ce");
   property p_we_drive;
      !o_flash_we_n |-> o_flash_oe_n && o_dq_oe && $stable(o_dq);
   endproperty
   a_we_drive: assert property (p_we_drive) else $error("write data bad");
   property p_we_width;
      $fell(o_flash_we_n) |=> !o_flash_we_n ##1 o_flash_we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("strobe width");
   property p_confirm;
      $fell(o_flash_we_n) && last_q == fclsc_pkg::CMD_CLR_SETUP
         |-> o_dq == fclsc_pkg::CMD_CLR_CONFIRM;
   endproperty
   a_confirm: assert property (p_confirm) else $error("no confirm");
   property p_cfg_code;
      $fell(o_flash_we_n) && last_q == fclsc_pkg::CMD_CFG
         |-> o_dq[7:2] == 6'h00;
   endproperty
   a_cfg_code: assert property (p_cfg_code) else $error("bad code");
   c_confirm: cover property ($fell(o_flash_we_n)
      && o_dq == fclsc_pkg::CMD_CLR_CONFIRM);
   c_cfg: cover property ($fell(o_flash_we_n) && o_dq == fclsc_pkg::CMD_CFG);
   c_err: cover property (o_pslverr);
endmodule // fclsc_host_sva

bind fclsc_host fclsc_host_sva u_sva (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_psel(i_psel),
   .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_flash_ce_n(o_flash_ce_n),
   .o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n),
   .o_dq(o_dq), .o_dq_oe(o_dq_oe)
);

// >>> verification/fclsc_host_test.sv
// self-checking bench of the flash lock-clear host
module fclsc_host_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_mclk = 1'b0;
   logic        i_resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, ce_n, we_n, oe_n, dq_oe, rp_n, hv_en, sts;
   logic [7:0]  dq_in, dq_out;
   logic        master = 1'b0;
   logic        low_sup = 1'b0;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   // 25 MHz clock
   always #20 i_mclk = ~i_mclk;
   fclsc_host u_dut (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(1'b1),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_dq(dq_in),
      .i_status_output_pin(sts), .o_flash_ce_n(ce_n),
      .o_flash_we_n(we_n), .o_flash_oe_n(oe_n), .o_dq(dq_out),
      .o_dq_oe(dq_oe), .o_reset_powerdown_pin_n(rp_n),
      .o_override_high_voltage_en(hv_en)
   );
   fclsc_flash_model u_flash (
      .i_clk(i_mclk), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
      .i_dq(dq_out), .i_rp_n(rp_n), .i_hv(hv_en), .i_master(master),
      .i_low_supply(low_sup), .o_dq(dq_in), .o_sts(sts)
   );
   task automatic summarize();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge i_mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_mclk);
      penable <= 1'b1;
      do @(posedge i_mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
   endtask
   // start an operation and poll until done, then acknowledge
   task automatic op(input int b, output logic [31:0] s);
      wr(fclsc_pkg::OFS_CTRL, 32'h0000_0001 << b);
      s = 32'h0000_0000;
      while (s[fclsc_pkg::ST_DONE] !== 1'b1)
         rd(fclsc_pkg::OFS_STAT, s);
      wr(fclsc_pkg::OFS_CTRL, 32'h0000_0010);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      rd(fclsc_pkg::OFS_CFG, q);
      chk("cfg reset", fclsc_pkg::CFG_RESET, q);
      wr(fclsc_pkg::OFS_CFG, 32'hffff_ffff);
      rd(fclsc_pkg::OFS_CFG, q);
      chk("cfg mask", 32'h0000_0033, q);
      apb(1'b0, 8'h40, 32'h0000_0000, q, e);
      chk("unmapped error", 32'h0000_0001, 32'(e));
      chk("unmapped data", 32'h0000_0000, q);
      wr(fclsc_pkg::OFS_CFG, 32'h0000_0000);
   endtask
   task automatic t_clear(input logic m, hv, lo, input logic [7:0] sr,
                          input logic [3:0] lk);
      logic [31:0] s;
      master <= m;
      low_sup <= lo;
      u_flash.locks_q = 4'h5;
      wr(fclsc_pkg::OFS_CFG, 32'(hv) << fclsc_pkg::CFG_OVERRIDE);
      op(fclsc_pkg::CTRL_GO_CLEAR, s);
      chk("status byte", 32'(sr), 32'(s[7:0]));
      chk("clear error", 32'(sr[5]), 32'(s[fclsc_pkg::ST_CLR_ERR]));
      chk("lock bits", 32'(lk), 32'(u_flash.locks_q));
      chk("errors left", 32'h0000_0000, 32'(u_flash.sr_q[5:1]));
      chk("override pin", 32'(hv), 32'(hv_en));
   endtask
   task automatic t_cfg_pulse();
      logic [31:0] s, p0, p1;
      master <= 1'b0;
      low_sup <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr(fclsc_pkg::OFS_CFG, 32'(c));
         op(fclsc_pkg::CTRL_GO_CFG, s);
         chk("pin mode", 32'(c), 32'(u_flash.mode_q));
         chk("mode mirror", 32'(c), 32'(s[14:13]));
         rd(fclsc_pkg::OFS_PULSES, p0);
         op(fclsc_pkg::CTRL_GO_CLEAR, s);
         rd(fclsc_pkg::OFS_PULSES, p1);
         chk("pulse count", p0 + 32'(c % 2), p1);
      end
   endtask
   task automatic t_rp();
      logic [31:0] s;
      wr(fclsc_pkg::OFS_CFG, 32'h0000_0010);
      repeat (3) @(posedge i_mclk);
      chk("reset pin", 32'h0000_0000, 32'(rp_n));
      chk("mode after reset", 32'h0000_0000, 32'(u_flash.mode_q));
      op(fclsc_pkg::CTRL_GO_CLEAR, s);
      chk("mirror after reset", 32'h0000_0000, 32'(s[14:13]));
      chk("locks unknown", 32'h0000_0001,
          32'(s[fclsc_pkg::ST_LOCKS_UNK]));
      wr(fclsc_pkg::OFS_CFG, 32'h0000_0000);
      op(fclsc_pkg::CTRL_GO_CLEAR, s);
      chk("locks known", 32'h0000_0000,
          32'(s[fclsc_pkg::ST_LOCKS_UNK]));
      op(fclsc_pkg::CTRL_GO_RDSTS, s);
      chk("read status", 32'h0000_0080, 32'(s[7:0]));
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge i_mclk);
      i_resetn <= 1'b1;
      t_regs();
      t_clear(1'b0, 1'b0, 1'b0, 8'h80, 4'h0);
      t_clear(1'b1, 1'b0, 1'b0, 8'ha2, 4'h5);
      t_clear(1'b1, 1'b1, 1'b0, 8'h80, 4'h0);
      t_clear(1'b0, 1'b0, 1'b1, 8'ha8, 4'h5);
      t_cfg_pulse();
      t_rp();
      summarize();
   end
endmodule // fclsc_host_test
